/* File: qbr_pkg.sv */
// constants and types shared by the quad bank bilinear resampler
// Summary of operation
// - fetch integer point and its three neighbours
// - all four bank reads in one cycle
// - four banks by row and column parity
// - row bank address conditionally incremented by parity
// - drop address lsb after the increment
// - column address alike; concatenate row and column
// - parity muxes steer bank data to ports
// - bilinear weighted sum with unity gain
// - 4-bit fractions index 256-entry weight table
// - four 12x12 multiplies keep top 16 bits
// - three 16-bit adders, pipelined tree
// - function code 000 forces output zero
// - one coordinate in, one pixel out per clock
// - coordinate is 10 integer plus 4 fraction bits
`default_nettype none

package qbr_pkg;
    localparam int COORD_INT_W = 10;
    localparam int FRAC_W      = 4;
    localparam int COORD_W     = COORD_INT_W + FRAC_W;
    localparam int PIX_W       = 12;
    localparam int WEIGHT_W    = 12;
    localparam int PROD_W      = PIX_W + WEIGHT_W;
    localparam int KEEP_W      = 16;
    localparam int SUM_W       = 16;
    localparam int BANK_ROW_W  = COORD_INT_W - 1;
    localparam int BANK_ADDR_W = 2 * BANK_ROW_W;
    localparam int BANK_DEPTH  = 1 << BANK_ADDR_W;
    localparam int NUM_BANKS   = 4;
    localparam int FN_W        = 3;
    localparam int LUT_IDX_W   = 2 * FRAC_W;
    // fraction unity is 16 sixteenths; weights scaled so unity product is 2048
    localparam logic [FRAC_W:0]   FRAC_UNITY   = 5'h10;
    localparam int                WEIGHT_SHIFT = 3;
    localparam logic [FN_W-1:0]   FN_FORCE_ZERO = 3'h0;
    localparam logic [SUM_W-1:0]  SUM_ZERO      = 16'h0000;
    // port index bits: bit0 selects x+1, bit1 selects y+1
    localparam int PORT_XINC_BIT = 0;
    localparam int PORT_YINC_BIT = 1;
    // parity bit of an integer coordinate, and the number of parities
    localparam int PAR_BIT       = 0;
    localparam int NUM_PAR       = 2;

    typedef logic [PIX_W-1:0]    qbr_pix_t;
    typedef logic [WEIGHT_W-1:0] qbr_weight_t;
    typedef logic [KEEP_W-1:0]   qbr_prod_t;
    typedef logic [SUM_W-1:0]    qbr_sum_t;
endpackage

`default_nettype wire

/* File: qbr_weight_rom.sv */
// registered 256-entry table of the four bilinear weights
`timescale 1ns/100ps
`default_nettype none

module qbr_weight_rom (
    input  wire logic                                                 clk,
    input  wire logic                                                 rst,
    input  wire logic [qbr_pkg::FRAC_W-1:0]                           frac_x,
    input  wire logic [qbr_pkg::FRAC_W-1:0]                           frac_y,
    output var  logic [qbr_pkg::NUM_BANKS-1:0][qbr_pkg::WEIGHT_W-1:0] weight_q
);
    import qbr_pkg::*;

    // ------------------------------------------------------------
    // table contents
    // ------------------------------------------------------------
    function automatic logic [NUM_BANKS-1:0][WEIGHT_W-1:0] weights_of(
        input logic [LUT_IDX_W-1:0] idx);
        logic [WEIGHT_W-1:0]      fx;
        logic [WEIGHT_W-1:0]      fy;
        logic [WEIGHT_W-1:0]      cx;
        logic [WEIGHT_W-1:0]      cy;
        logic [NUM_BANKS-1:0][WEIGHT_W-1:0] w;
        // work at weight width so the unity corner (16 x 16) cannot wrap
        fx = WEIGHT_W'(idx[FRAC_W-1:0]);
        fy = WEIGHT_W'(idx[LUT_IDX_W-1:FRAC_W]);
        cx = WEIGHT_W'(FRAC_UNITY) - fx;
        cy = WEIGHT_W'(FRAC_UNITY) - fy;
        // the four weights sum to unity for every index
        w[0] = (cx * cy) << WEIGHT_SHIFT;
        w[1] = (fx * cy) << WEIGHT_SHIFT;
        w[2] = (cx * fy) << WEIGHT_SHIFT;
        w[3] = (fx * fy) << WEIGHT_SHIFT;
        return w;
    endfunction

    logic [NUM_BANKS-1:0][WEIGHT_W-1:0] rom [1 << LUT_IDX_W];

    always_comb begin
        for (int i = 0; i < (1 << LUT_IDX_W); i++) begin
            rom[i] = weights_of(LUT_IDX_W'(i));
        end
    end

    // ------------------------------------------------------------
    // lookup, all four weights in parallel
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            weight_q <= '0;
        end else begin
            weight_q <= rom[{frac_y, frac_x}];
        end
    end

endmodule

`default_nettype wire

/* File: qbr_resampler.sv */
// four-bank frame store with pipelined bilinear interpolator
`timescale 1ns/100ps
`default_nettype none

module qbr_resampler (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // frame store load port, filtered source pixels
    input  wire logic                                 store_wr_en,
    input  wire logic [qbr_pkg::COORD_INT_W-1:0]      store_wr_x,
    input  wire logic [qbr_pkg::COORD_INT_W-1:0]      store_wr_y,
    input  wire logic [qbr_pkg::PIX_W-1:0]            store_wr_data,
    // source coordinate stream
    input  wire logic                                 coord_valid,
    input  wire logic [qbr_pkg::COORD_W-1:0]          coord_x,
    input  wire logic [qbr_pkg::COORD_W-1:0]          coord_y,
    // function code of the final adder from the system controller
    input  wire logic [qbr_pkg::FN_W-1:0]             fn_code,
    // result towards display memory
    output var  logic                                 pix_valid,
    output var  logic [qbr_pkg::SUM_W-1:0]            pix_out
);
    import qbr_pkg::*;

    // ------------------------------------------------------------
    // address helpers
    // ------------------------------------------------------------
    // bank half-address: increment when parity differs, then drop lsb
    function automatic logic [BANK_ROW_W-1:0] half_addr(
        input logic [COORD_INT_W-1:0] v,
        input logic                   odd_bank);
        logic [COORD_INT_W:0] s;
        s = {1'b0, v} + {{COORD_INT_W{1'b0}}, v[PAR_BIT] ^ odd_bank};
        return s[BANK_ROW_W:PAR_BIT+1];
    endfunction

    // bank holding a pixel: {row parity, column parity}
    function automatic logic [1:0] bank_of(
        input logic ypar,
        input logic xpar);
        return {ypar, xpar};
    endfunction

    // packed location of a pixel inside its bank
    function automatic logic [BANK_ADDR_W-1:0] store_addr(
        input logic [COORD_INT_W-1:0] y,
        input logic [COORD_INT_W-1:0] x);
        return {y[COORD_INT_W-1:PAR_BIT+1], x[COORD_INT_W-1:PAR_BIT+1]};
    endfunction

    // bank feeding output port k: port k sits at (x + k.x, y + k.y)
    function automatic logic [1:0] port_bank(
        input logic ypar,
        input logic xpar,
        input int   k);
        logic yinc;
        logic xinc;
        yinc = k[PORT_YINC_BIT];
        xinc = k[PORT_XINC_BIT];
        return bank_of(ypar ^ yinc, xpar ^ xinc);
    endfunction

    // ------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------
    // 12x12 product keeping only the upper sixteen bits
    function automatic qbr_prod_t mul_keep(
        input qbr_pix_t    pix,
        input qbr_weight_t w);
        logic [PROD_W-1:0] p;
        p = {{WEIGHT_W{1'b0}}, pix} * {{PIX_W{1'b0}}, w};
        return p[PROD_W-1:PROD_W-KEEP_W];
    endfunction

    // one adder of the summing tree; the carry out is dropped on purpose
    function automatic qbr_sum_t add_keep(
        input qbr_sum_t a,
        input qbr_sum_t b);
        logic [SUM_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[SUM_W-1:0];
    endfunction

    // final adder stage: the force-to-zero code replaces the sum
    function automatic qbr_sum_t final_stage(
        input logic [FN_W-1:0] fn,
        input qbr_sum_t        sum);
        qbr_sum_t r;
        if (fn == FN_FORCE_ZERO) begin
            r = SUM_ZERO;
        end else begin
            r = sum;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // pipeline state
    // ------------------------------------------------------------
    typedef struct packed {
        // stage 1: bank reads in flight
        logic                           s1_valid;
        logic                           s1_ypar;
        logic                           s1_xpar;
        logic [FN_W-1:0]                s1_fn;
        // stage 2: weighted products
        logic                           s2_valid;
        logic [FN_W-1:0]                s2_fn;
        logic [NUM_BANKS-1:0][KEEP_W-1:0] s2_prod;
        // stage 3: first adder rank
        logic                           s3_valid;
        logic [FN_W-1:0]                s3_fn;
        logic [SUM_W-1:0]               s3_sum_top;
        logic [SUM_W-1:0]               s3_sum_bot;
        // stage 4: output register
        logic                           out_valid;
        logic [SUM_W-1:0]               out_pix;
    } qbr_state_t;

    qbr_state_t state_q;
    qbr_state_t state_d;

    // ------------------------------------------------------------
    // frame store banks
    // ------------------------------------------------------------
    // bank index is {row parity, column parity}
    logic [PIX_W-1:0]        bank_mem [NUM_BANKS][BANK_DEPTH];
    logic [PIX_W-1:0]        bank_rd_q [NUM_BANKS];
    logic [BANK_ADDR_W-1:0]  rd_addr [NUM_BANKS];
    logic [BANK_ROW_W-1:0]   row_addr [NUM_PAR];
    logic [BANK_ROW_W-1:0]   col_addr [NUM_PAR];
    logic [COORD_INT_W-1:0]  x_int;
    logic [COORD_INT_W-1:0]  y_int;
    logic [1:0]              wr_bank;
    logic [BANK_ADDR_W-1:0]  wr_addr;

    assign x_int = coord_x[COORD_W-1:FRAC_W];
    assign y_int = coord_y[COORD_W-1:FRAC_W];

    always_comb begin
        for (int p = 0; p < NUM_PAR; p++) begin
            row_addr[p] = half_addr(y_int, p[0]);
            col_addr[p] = half_addr(x_int, p[0]);
        end
        for (int b = 0; b < NUM_BANKS; b++) begin
            rd_addr[b] = {row_addr[b / NUM_PAR], col_addr[b % NUM_PAR]};
        end
    end

    assign wr_bank = bank_of(store_wr_y[PAR_BIT], store_wr_x[PAR_BIT]);
    assign wr_addr = store_addr(store_wr_y, store_wr_x);

    // all four banks read in the same cycle
    always_ff @(posedge clk) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            bank_rd_q[b] <= bank_mem[b][rd_addr[b]];
            if (store_wr_en && (wr_bank == 2'(b))) begin
                bank_mem[b][wr_addr] <= store_wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // weight table, aligned with the bank reads
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0][WEIGHT_W-1:0] weight_q;

    qbr_weight_rom u_weight_rom (
        .clk      (clk),
        .rst      (rst),
        .frac_x   (coord_x[FRAC_W-1:0]),
        .frac_y   (coord_y[FRAC_W-1:0]),
        .weight_q (weight_q)
    );

    // ------------------------------------------------------------
    // interpolator datapath
    // ------------------------------------------------------------
    qbr_pix_t  port_pix [NUM_BANKS];
    logic [1:0] sel;
    qbr_sum_t  final_sum;

    always_comb begin
        state_d = state_q;

        // stage 1 captures parity and control beside the bank reads
        state_d.s1_valid = coord_valid;
        state_d.s1_ypar  = y_int[PAR_BIT];
        state_d.s1_xpar  = x_int[PAR_BIT];
        state_d.s1_fn    = fn_code;

        // steer banks to ports by the parity of the fetched point
        for (int k = 0; k < NUM_BANKS; k++) begin
            sel = port_bank(state_q.s1_ypar, state_q.s1_xpar, k);
            port_pix[k] = bank_rd_q[sel];
            state_d.s2_prod[k] = mul_keep(port_pix[k], weight_q[k]);
        end
        state_d.s2_valid = state_q.s1_valid;
        state_d.s2_fn    = state_q.s1_fn;

        // first adder rank: two adders
        state_d.s3_sum_top = add_keep(state_q.s2_prod[0], state_q.s2_prod[1]);
        state_d.s3_sum_bot = add_keep(state_q.s2_prod[2], state_q.s2_prod[3]);
        state_d.s3_valid   = state_q.s2_valid;
        state_d.s3_fn      = state_q.s2_fn;

        // final adder, with force-to-zero function
        final_sum = add_keep(state_q.s3_sum_top, state_q.s3_sum_bot);
        state_d.out_valid = state_q.s3_valid;
        state_d.out_pix = final_stage(state_q.s3_fn, final_sum);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pix_valid = state_q.out_valid;
    assign pix_out   = state_q.out_pix;

endmodule

`default_nettype wire

/* File: qbr_dummy_end.sv */
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

/* File: qbr_resampler_properties.sv */
// concurrent checks on the resampler ports
`timescale 1ns/100ps
`default_nettype none
module qbr_resampler_chk (
    input wire logic                         clk,
    input wire logic                         rst,
    input wire logic                         store_wr_en,
    input wire logic                         coord_valid,
    input wire logic [qbr_pkg::COORD_W-1:0]  coord_x,
    input wire logic [qbr_pkg::COORD_W-1:0]  coord_y,
    input wire logic [qbr_pkg::FN_W-1:0]     fn_code,
    input wire logic                         pix_valid,
    input wire logic [qbr_pkg::SUM_W-1:0]    pix_out
);
    import qbr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_out_latency: assert property (coord_valid |-> ##4 pix_valid)
        else $error("no result four cycles after coordinate");
    chk_no_spurious: assert property (!coord_valid |-> ##4 !pix_valid)
        else $error("result without coordinate");
    chk_back_to_back: assert property (coord_valid ##1 coord_valid |-> ##3 pix_valid [*2])
        else $error("back to back results dropped");
    chk_force_zero: assert property (
        coord_valid && fn_code == FN_FORCE_ZERO |-> ##4 pix_out == SUM_ZERO)
        else $error("blanked result not zero");
    chk_whole_point: assert property (
        coord_valid && coord_x[3:0] == 4'h0 && coord_y[3:0] == 4'h0 |-> ##4 pix_out[2:0] == 3'h0)
        else $error("whole point result has fraction bits");
    chk_unity_gain: assert property (pix_valid |-> pix_out <= 16'h7FF8)
        else $error("result above unity gain");
    chk_same_input: assert property (
        coord_valid && $past(coord_valid) && $stable(coord_x) && $stable(coord_y)
        && $stable(fn_code) && !store_wr_en && !$past(store_wr_en) |-> ##4 $stable(pix_out))
        else $error("same input gave different result");
    chk_reset_idle: assert property ($fell(rst) |-> !pix_valid && pix_out == SUM_ZERO)
        else $error("output busy after reset");
endmodule
bind qbr_resampler qbr_resampler_chk chk_u (.clk(clk), .rst(rst), .store_wr_en(store_wr_en),
    .coord_valid(coord_valid), .coord_x(coord_x), .coord_y(coord_y), .fn_code(fn_code),
    .pix_valid(pix_valid), .pix_out(pix_out));
`default_nettype wire

/* File: qbr_display_mem.sv */
// display memory model storing each result in scan order
`timescale 1ns/100ps
`default_nettype none
module qbr_display_mem (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       wr_en,
    input wire logic [qbr_pkg::SUM_W-1:0]  wr_data
);
    import qbr_pkg::*;
    qbr_sum_t    mem [0:255];
    int unsigned wr_ptr;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 0;
        end else if (wr_en) begin
            mem[wr_ptr[7:0]] <= wr_data;
            wr_ptr <= wr_ptr + 1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the bilinear resampler
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import qbr_pkg::*;
    localparam logic [3:0] FX_TAB [4] = '{4'h0, 4'hF, 4'h8, 4'h1};
    localparam logic [3:0] FY_TAB [4] = '{4'h0, 4'hF, 4'h3, 4'hE};
    logic clk, rst, store_wr_en, coord_valid, pix_valid;
    logic [9:0] store_wr_x, store_wr_y;
    logic [11:0] store_wr_data;
    logic [13:0] coord_x, coord_y;
    logic [2:0] fn_code;
    logic [15:0] pix_out;
    logic [11:0] img [int];
    logic [15:0] exp_q [$];
    int errors, num_checks;
    qbr_resampler dut_u (.clk(clk), .rst(rst), .store_wr_en(store_wr_en),
        .store_wr_x(store_wr_x), .store_wr_y(store_wr_y), .store_wr_data(store_wr_data),
        .coord_valid(coord_valid), .coord_x(coord_x), .coord_y(coord_y), .fn_code(fn_code),
        .pix_valid(pix_valid), .pix_out(pix_out));
    qbr_display_mem disp_u (.clk(clk), .rst(rst), .wr_en(pix_valid), .wr_data(pix_out));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [15:0] model(input logic [9:0] xi, yi, input logic [3:0] fx, fy,
                                          input logic [2:0] fn);
        int w [4];
        int p [4];
        logic [15:0] s;
        w = '{(16 - fx) * (16 - fy) * 8, fx * (16 - fy) * 8, (16 - fx) * fy * 8, fx * fy * 8};
        p = '{img[{yi, xi}], img[{yi, 10'(xi + 1)}], img[{10'(yi + 1), xi}],
              img[{10'(yi + 1), 10'(xi + 1)}]};
        s = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            s += 16'((p[k] * w[k]) >> 8);
        end
        return (fn == 3'h0) ? 16'h0000 : s;
    endfunction
    task automatic send(input logic [9:0] xi, yi, input logic [3:0] fx, fy, input logic [2:0] fn);
        @(negedge clk);
        coord_valid = 1'b1;
        coord_x = {xi, fx};
        coord_y = {yi, fy};
        fn_code = fn;
        exp_q.push_back(model(xi, yi, fx, fy, fn));
    endtask
    task automatic idle();
        @(negedge clk);
        coord_valid = 1'b0;
    endtask
    task automatic drain(input string name);
        idle();
        repeat (6) @(negedge clk);
        check(16'(disp_u.wr_ptr), 16'(exp_q.size()));
        for (int i = 0; i < exp_q.size(); i++) begin
            check(disp_u.mem[i], exp_q[i]);
        end
        $display("test %s done: checks=%0d errors=%0d", name, num_checks, errors);
    endtask
    task automatic t_load();
        logic [9:0] px, py;
        for (int i = 0; i < 25; i++) begin
            @(negedge clk);
            px = (i % 5 == 4) ? 10'h3FF : 10'(i % 5);
            py = (i / 5 == 4) ? 10'h3FF : 10'(i / 5);
            store_wr_en = 1'b1;
            store_wr_x = px;
            store_wr_y = py;
            store_wr_data = (i == 6) ? 12'hFFF : 12'(px * 613 + py * 1409 + 165);
            img[{py, px}] = store_wr_data;
            check(16'(pix_valid), 16'h0000);
        end
        @(negedge clk);
        store_wr_en = 1'b0;
        $display("test load done: checks=%0d errors=%0d", num_checks, errors);
    endtask
    task automatic t_interp();
        for (int n = 0; n < 36; n++) begin
            send(10'(n / 12), 10'((n / 4) % 3), FX_TAB[n % 4], FY_TAB[n % 4], 3'(1 + n % 7));
        end
        drain("interp");
    endtask
    task automatic t_blank();
        for (int k = 0; k < 16; k++) begin
            send(10'(k % 3), 10'h002, 4'(k), 4'(15 - k), k[0] ? 3'(k >> 1) : 3'h0);
        end
        drain("blank");
    endtask
    task automatic t_wrap();
        send(10'h3FF, 10'h3FF, 4'h9, 4'h7, 3'h5);
        send(10'h3FF, 10'h3FF, 4'h9, 4'h7, 3'h5);
        idle();
        send(10'h3FF, 10'h000, 4'h3, 4'hC, 3'h2);
        idle();
        idle();
        send(10'h000, 10'h3FF, 4'hF, 4'h1, 3'h4);
        drain("wrap");
    endtask
    initial begin
        rst = 1'b1;
        {store_wr_en, coord_valid, store_wr_x, store_wr_y, store_wr_data} = '0;
        {coord_x, coord_y, fn_code} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_load();
        t_interp();
        t_blank();
        t_wrap();
        results();
    end
    initial begin
        #20000;
        errors++;
        $display("watchdog expired");
        results();
    end
endmodule
`default_nettype wire
